// ---- logic/mcu_alu_skip_table_ops.sv ----
// datapath for rotates, subtracts, skips, nibble swap, table reads and xor
`timescale 1ns/10ps
module mcu_alu_skip_table_ops
    import alu_skip_pkg::*;
#(
    parameter int MEM_DEPTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [ROM_AW-1:0] rom_addr,
    output logic rom_rd,
    input wire logic [ROM_W-1:0] rom_data,
    output logic discard_next
);
    state_t state_q, state_d;
    cmd_t cmd_q;
    flags_t flags_q, alu_flags;
    logic [DATA_W-1:0] acc_q, imm_q, table_pointer_reg_q, table_high_latch_q;
    logic [PAGE_W-1:0] page_q;
    logic [DATA_W-1:0] mem_q [MEM_DEPTH];
    logic [1:0] last_cycles_q;
    logic skip_seen_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic [ROM_AW-1:0] rom_addr_q;
    logic rom_rd_q, discard_q;

    // apb decode, setup phase
    wire setup = psel && !penable && !pready_q;
    wire commit = psel && penable && pready_q;
    wire wr_commit = commit && pwrite && !pslverr_q;
    wire in_mem = (paddr >= ADDR_MEM) && (paddr < ADDR_MEM + 12'(MEM_DEPTH * 4));
    wire [PADDR_W-1:0] mem_off = paddr - ADDR_MEM;
    wire [IDX_W-1:0] bus_idx = mem_off[IDX_W+1:2];
    wire aligned = (paddr[1:0] == 2'h0);
    wire busy = (state_q != ST_IDLE);
    wire hit_cmd = (paddr == ADDR_CMD);
    wire hit_acc = (paddr == ADDR_ACC);
    wire hit_flags = (paddr == ADDR_FLAGS);
    wire hit_ptr = (paddr == ADDR_PTR);
    wire hit_high = (paddr == ADDR_HIGH);
    wire hit_imm = (paddr == ADDR_IMM);
    wire hit_stat = (paddr == ADDR_STAT);
    wire hit_page = (paddr == ADDR_PAGE);
    wire hit_any = aligned && (hit_cmd || hit_acc || hit_flags || hit_ptr || hit_high ||
                               hit_imm || hit_stat || hit_page || in_mem);
    // the high byte and status registers refuse writes; command refused while busy
    // so a running op never sees its operand selection change under it
    wire bad_wr = pwrite && (hit_high || hit_stat || (hit_cmd && busy));
    wire err_d = !hit_any || bad_wr;

    // read mux, sampled in the setup cycle so data stands through access
    // misaligned reads answer zero so no stray lane leaks out
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_acc) rd_mux = {24'h00_0000, acc_q};
        if (hit_flags) rd_mux = {28'h000_0000, flags_q};
        if (hit_ptr) rd_mux = {24'h00_0000, table_pointer_reg_q};
        if (hit_high) rd_mux = {24'h00_0000, table_high_latch_q};
        if (hit_imm) rd_mux = {24'h00_0000, imm_q};
        if (hit_cmd) rd_mux = 32'(cmd_q);
        if (hit_page) rd_mux = {27'h000_0000, page_q};
        if (hit_stat) rd_mux = {26'h000_0000, last_cycles_q, 2'h0, skip_seen_q, busy};
        if (in_mem) rd_mux = {24'h00_0000, mem_q[bus_idx]};
        if (!aligned) rd_mux = 32'h0000_0000;
    end

    // operand fetch
    op_t op;
    assign op = op_t'(cmd_q.op);
    wire [DATA_W-1:0] m = mem_q[cmd_q.idx];
    wire c_in = flags_q.carry_flag;
    wire [DATA_W-1:0] rom_lo = rom_data[DATA_W-1:0];
    wire [DATA_W-1:0] rom_hi = rom_data[ROM_W-1:DATA_W];

    // four-bit slice of the subtract adder, carry out in bit 4
    function automatic logic [4:0] nib_add(input logic [3:0] a, input logic [3:0] b,
                                           input logic ci);
        nib_add = {1'b0, a} + {1'b0, b} + {4'h0, ci};
    endfunction

    // zero test shared by the byte-zero skips (not the bit test) and the zero flag
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        is_zero = (v == BYTE_ZERO);
    endfunction

    // one adder serves every subtract form: acc + ~operand + carry-in
    // split in nibbles so the nibble carry falls out without a second adder
    wire is_imm_sub = (op == subtract_immediate);
    wire is_borrow = (op == subtract_with_borrow) || (op == subtract_with_borrow_to_mem);
    wire [DATA_W-1:0] sub_b = ~(is_imm_sub ? imm_q : m);
    wire sub_cin = is_borrow ? c_in : 1'b1;
    wire [4:0] lo_sum = nib_add(acc_q[3:0], sub_b[3:0], sub_cin);
    wire [4:0] hi_sum = nib_add(acc_q[7:4], sub_b[7:4], lo_sum[4]);
    wire [DATA_W-1:0] sub_res = {hi_sum[3:0], lo_sum[3:0]};
    wire sub_ovf = (acc_q[7] == sub_b[7]) && (sub_res[7] != acc_q[7]);

    // rotate, decrement, swap and xor results
    wire [DATA_W-1:0] rotl_c_res = {m[6:0], c_in};
    wire [DATA_W-1:0] rotr_res = {m[0], m[7:1]};
    wire [DATA_W-1:0] rotr_c_res = {c_in, m[7:1]};
    wire [DATA_W-1:0] dec_res = m - BYTE_ONE;
    wire [DATA_W-1:0] swp_res = {m[3:0], m[7:4]};
    wire is_xor_imm = (op == exclusive_or_immediate);
    wire [DATA_W-1:0] xor_res = acc_q ^ (is_xor_imm ? imm_q : m);

    // per-op result, destination and skip selection
    logic [DATA_W-1:0] res;
    logic to_mem, to_acc, skip;
    always_comb begin
        res = BYTE_ZERO;
        to_mem = 1'b0;
        to_acc = 1'b0;
        skip = 1'b0;
        alu_flags = flags_q;
        unique case (op)
            rotate_left_thru_carry: begin
                res = rotl_c_res;
                to_mem = 1'b1;
                alu_flags.carry_flag = m[7];
            end
            rotate_left_thru_carry_to_acc: begin
                res = rotl_c_res;
                to_acc = 1'b1;
                alu_flags.carry_flag = m[7];
            end
            rotate_right_plain: begin
                res = rotr_res;
                to_mem = 1'b1;
            end
            rotate_right_to_acc: begin
                res = rotr_res;
                to_acc = 1'b1;
            end
            rotate_right_thru_carry: begin
                res = rotr_c_res;
                to_mem = 1'b1;
                alu_flags.carry_flag = m[0];
            end
            rotate_right_thru_carry_to_acc: begin
                res = rotr_c_res;
                to_acc = 1'b1;
                alu_flags.carry_flag = m[0];
            end
            subtract_with_borrow, subtract_from_acc, subtract_immediate,
            subtract_with_borrow_to_mem, subtract_to_mem: begin
                res = sub_res;
                to_mem = (op == subtract_with_borrow_to_mem) || (op == subtract_to_mem);
                to_acc = !to_mem;
                alu_flags.carry_flag = hi_sum[4];
                alu_flags.nibble_carry_flag = lo_sum[4];
                alu_flags.zero_flag = is_zero(sub_res);
                alu_flags.signed_excess_flag = sub_ovf;
            end
            decrement_skip_zero: begin
                res = dec_res;
                to_mem = 1'b1;
                skip = is_zero(dec_res);
            end
            decrement_skip_zero_to_acc: begin
                res = dec_res;
                to_acc = 1'b1;
                skip = is_zero(dec_res);
            end
            test_skip_zero: begin
                skip = is_zero(m);
            end
            move_test_skip_zero: begin
                res = m;
                to_acc = 1'b1;
                skip = is_zero(m);
            end
            bit_test_skip_zero: begin
                skip = !m[cmd_q.bit_sel];
            end
            nibble_exchange: begin
                res = swp_res;
                to_mem = 1'b1;
            end
            nibble_exchange_to_acc: begin
                res = swp_res;
                to_acc = 1'b1;
            end
            table_read_current_page, table_read_last_page: begin
                res = rom_lo;
                to_mem = 1'b1;
            end
            exclusive_or, exclusive_or_immediate, exclusive_or_to_mem: begin
                res = xor_res;
                to_mem = (op == exclusive_or_to_mem);
                to_acc = !to_mem;
                alu_flags.zero_flag = is_zero(xor_res);
            end
            default: begin
                res = BYTE_ZERO; // unknown op code does nothing
            end
        endcase
    end

    // table ops are the only ones that wait a cycle for the program store
    function automatic logic is_table(input logic [4:0] code);
        is_table = (code == table_read_current_page) || (code == table_read_last_page);
    endfunction

    // sequencing: start on command write, table ops wait one rom cycle
    cmd_t new_cmd;
    assign new_cmd = cmd_t'(pwdata);
    wire start = wr_commit && hit_cmd;
    wire new_is_table = is_table(new_cmd.op);
    wire new_last = (new_cmd.op == table_read_last_page);
    wire exec = (state_q == ST_EXEC);
    wire exec_tbl = exec && is_table(op);
    wire [PAGE_W-1:0] rd_page = new_last ? LAST_PAGE : page_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (start) state_d = new_is_table ? ST_ROM_REQ : ST_EXEC;
            ST_ROM_REQ: state_d = ST_EXEC;
            ST_EXEC: state_d = skip ? ST_DUMMY : ST_IDLE;
            ST_DUMMY: state_d = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // bus answer: zero wait states, read data captured in the setup cycle
    // so the value read is the one that stood when the request was made
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup; // zero wait states
            pslverr_q <= setup ? err_d : 1'b0;
            if (setup) prdata_q <= rd_mux;
        end
    end

    // program store request; the address stays put until the next table op
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rom_rd_q <= 1'b0;
            rom_addr_q <= 13'h0000;
        end else begin
            rom_rd_q <= start && new_is_table;
            if (start && new_is_table) rom_addr_q <= {rd_page, table_pointer_reg_q};
        end
    end

    // one-cycle discard strobe marks the dummy cycle of a taken skip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            discard_q <= 1'b0;
        end else begin
            discard_q <= exec && skip;
        end
    end

    // command latch, held for the whole op so its operands stay selected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= '0;
        end else if (start) begin
            cmd_q <= new_cmd;
        end
    end

    // immediate operand, software owned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imm_q <= BYTE_ZERO;
        end else if (wr_commit && hit_imm) begin
            imm_q <= pwdata[DATA_W-1:0];
        end
    end

    // table pointer, software owned
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_pointer_reg_q <= BYTE_ZERO;
        end else if (wr_commit && hit_ptr) begin
            table_pointer_reg_q <= pwdata[DATA_W-1:0];
        end
    end

    // current code page, only read when a table op starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_q <= 5'h00;
        end else if (wr_commit && hit_page) begin
            page_q <= pwdata[PAGE_W-1:0];
        end
    end

    // accumulator; the executing op wins over a same-cycle bus write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= BYTE_ZERO;
        end else if (exec && to_acc) begin
            acc_q <= res;
        end else if (wr_commit && hit_acc) begin
            acc_q <= pwdata[DATA_W-1:0];
        end
    end

    // flags; the executing op wins over a same-cycle bus write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= '0;
        end else if (exec) begin
            flags_q <= alu_flags;
        end else if (wr_commit && hit_flags) begin
            flags_q <= flags_t'(pwdata[3:0]);
        end
    end

    // high byte of the fetched program word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_high_latch_q <= BYTE_ZERO;
        end else if (exec_tbl) begin
            table_high_latch_q <= rom_hi;
        end
    end

    // status of the last op, kept for software to read back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_cycles_q <= 2'h0;
            skip_seen_q <= 1'b0;
        end else if (exec) begin
            last_cycles_q <= skip ? CYC_SKIP : CYC_PLAIN;
            skip_seen_q <= skip;
        end
    end

    // data memory in flip-flops; the executing op owns its own location
    // a bus write to the word an op updates in that same cycle is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < MEM_DEPTH; i++) mem_q[i] <= BYTE_ZERO;
        end else begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                if (exec && to_mem && (cmd_q.idx == IDX_W'(i))) mem_q[i] <= res;
                else if (wr_commit && in_mem && (bus_idx == IDX_W'(i)))
                    mem_q[i] <= pwdata[DATA_W-1:0];
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign rom_addr = rom_addr_q;
    assign rom_rd = rom_rd_q;
    assign discard_next = discard_q;
endmodule

// ---- logic/alu_skip_pkg.sv ----
// constants, types and register map for the skip and table datapath
// How it works
// - rotate left through carry to memory, carry in bit 0, bit 7 to carry
// - same nine-bit left rotation to accumulator only, carry updated, memory kept
// - plain right rotate to memory, bit 0 wraps to bit 7, no flags
// - plain right rotate to accumulator only, memory and flags kept
// - rotate right through carry to memory, carry to bit 7, bit 0 to carry
// - same nine-bit right rotation to accumulator only, memory kept
// - subtract with borrow: acc plus inverted operand plus carry, four flags
// - subtract: acc plus inverted operand plus one, to acc or memory
// - subtract immediate: acc plus inverted immediate plus one into acc
// - decrement to memory, skip next when result is zero, no flags
// - decrement to accumulator, memory kept, skip when zero, no flags
// - taken skip discards prefetched word with a dummy cycle, two cycles
// - test memory byte for zero, skip when zero, nothing modified
// - copy memory byte to accumulator, skip when copied value is zero
// - test one selected memory bit, skip when it is zero
// - nibble exchange to memory or accumulator only, flags kept
// - table read in current page: low byte to memory, high byte latched
// - table read in last page: low byte to memory, high byte latched
// - exclusive-or with memory or immediate, only zero flag updated
package alu_skip_pkg;
    localparam int DATA_W = 8;
    localparam int ROM_W = 16;
    localparam int ROM_AW = 13;
    localparam int PTR_W = 8;
    localparam int PAGE_W = ROM_AW - PTR_W;
    localparam int PADDR_W = 12;
    localparam int IDX_W = 3;

    // register byte offsets
    localparam logic [PADDR_W-1:0] ADDR_CMD = 12'h000;
    localparam logic [PADDR_W-1:0] ADDR_ACC = 12'h004;
    localparam logic [PADDR_W-1:0] ADDR_FLAGS = 12'h008;
    localparam logic [PADDR_W-1:0] ADDR_PTR = 12'h00c;
    localparam logic [PADDR_W-1:0] ADDR_HIGH = 12'h010;
    localparam logic [PADDR_W-1:0] ADDR_IMM = 12'h014;
    localparam logic [PADDR_W-1:0] ADDR_STAT = 12'h018;
    localparam logic [PADDR_W-1:0] ADDR_PAGE = 12'h01c;
    localparam logic [PADDR_W-1:0] ADDR_MEM = 12'h040;

    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
    localparam logic [PAGE_W-1:0] LAST_PAGE = 5'h1f;
    localparam logic [1:0] CYC_PLAIN = 2'h1;
    localparam logic [1:0] CYC_SKIP = 2'h2;

    typedef enum logic [4:0] {
        rotate_left_thru_carry = 5'h00,
        rotate_left_thru_carry_to_acc = 5'h01,
        rotate_right_plain = 5'h02,
        rotate_right_to_acc = 5'h03,
        rotate_right_thru_carry = 5'h04,
        rotate_right_thru_carry_to_acc = 5'h05,
        subtract_with_borrow = 5'h06,
        subtract_with_borrow_to_mem = 5'h07,
        subtract_from_acc = 5'h08,
        subtract_to_mem = 5'h09,
        subtract_immediate = 5'h0a,
        decrement_skip_zero = 5'h0b,
        decrement_skip_zero_to_acc = 5'h0c,
        test_skip_zero = 5'h0d,
        move_test_skip_zero = 5'h0e,
        bit_test_skip_zero = 5'h0f,
        nibble_exchange = 5'h10,
        nibble_exchange_to_acc = 5'h11,
        table_read_current_page = 5'h12,
        table_read_last_page = 5'h13,
        exclusive_or = 5'h14,
        exclusive_or_to_mem = 5'h15,
        exclusive_or_immediate = 5'h16
    } op_t;

    // command word: op in [4:0], bit select in [10:8], memory index in [18:16]
    typedef struct packed {
        logic [12:0] unused_hi;
        logic [IDX_W-1:0] idx;
        logic [4:0] unused_mid;
        logic [2:0] bit_sel;
        logic [2:0] unused_lo;
        logic [4:0] op;
    } cmd_t;

    // flag register: bit 0 carry, 1 nibble carry, 2 zero, 3 signed excess
    typedef struct packed {
        logic signed_excess_flag;
        logic zero_flag;
        logic nibble_carry_flag;
        logic carry_flag;
    } flags_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ROM_REQ = 2'b01,
        ST_EXEC = 2'b10,
        ST_DUMMY = 2'b11
    } state_t;
endpackage

// ---- tb/mcu_alu_skip_table_ops_asserts.sv ----
// port-level checks for the skip and table datapath
`timescale 1ns/10ps
module mcu_alu_skip_table_ops_asserts
    import alu_skip_pkg::*;
#(
    parameter int MEM_DEPTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [ROM_AW-1:0] rom_addr,
    input wire logic rom_rd,
    input wire logic [ROM_W-1:0] rom_data,
    input wire logic discard_next
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // accepted command writes, split by the kind of op they start
    wire logic setup_w = psel && !penable;
    wire logic cmd_ok = psel && penable && pready && pwrite && !pslverr && paddr == ADDR_CMD;
    wire logic cmd_tbl = cmd_ok && (pwdata[4:0] == 5'h12 || pwdata[4:0] == 5'h13);
    wire logic cmd_last = cmd_ok && pwdata[4:0] == 5'h13;
    wire logic cmd_skip = cmd_ok && pwdata[4:0] >= 5'h0b && pwdata[4:0] <= 5'h0f;

    sequence s_setup;
        setup_w;
    endsequence
    sequence s_cmd_tbl;
        cmd_tbl;
    endsequence
    sequence s_fetch;
        rom_rd ##1 !rom_rd;
    endsequence

    chk_ready_setup: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    chk_ready_cause: assert property (pready |-> $past(setup_w))
        else $error("ready without setup");
    chk_err_align: assert property ((setup_w && paddr[1:0] != 2'h0) |=> pslverr)
        else $error("misaligned access accepted");
    chk_table_fetch: assert property (s_cmd_tbl |=> s_fetch)
        else $error("table op without one fetch pulse");
    chk_last_page: assert property (cmd_last |=> rom_addr[12:8] == LAST_PAGE)
        else $error("last page fetch off page");
    chk_fetch_cause: assert property (rom_rd |-> $past(cmd_tbl))
        else $error("fetch without table op");
    chk_table_noskip: assert property (s_cmd_tbl |=> !discard_next [*3])
        else $error("table op discarded a word");
    chk_skip_pulse: assert property (discard_next |=> !discard_next)
        else $error("dummy cycle longer than one");
    chk_skip_cause: assert property (discard_next |-> $past(cmd_skip, 2))
        else $error("discard without skip op");
    chk_addr_held: assert property ($changed(rom_addr) |-> rom_rd)
        else $error("fetch address moved between fetches");
endmodule

bind mcu_alu_skip_table_ops mcu_alu_skip_table_ops_asserts #(.MEM_DEPTH(MEM_DEPTH))
    i_mcu_alu_skip_table_ops_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rom_addr(rom_addr), .rom_rd(rom_rd),
    .rom_data(rom_data), .discard_next(discard_next));

// ---- tb/test_mcu_alu_skip_table_ops.sv ----
// self-checking bench for the skip and table datapath
`timescale 1ns/10ps
module test_mcu_alu_skip_table_ops
    import alu_skip_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [PADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [ROM_AW-1:0] rom_addr;
    logic rom_rd;
    logic [ROM_W-1:0] rom_data = 16'h0;
    logic discard_next;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [31:0] rdat;
    logic rerr;

    mcu_alu_skip_table_ops #(.MEM_DEPTH(8)) i_mcu_alu_skip_table_ops (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rom_addr(rom_addr), .rom_rd(rom_rd), .rom_data(rom_data), .discard_next(discard_next));

    // 100 MHz clock
    initial begin
        forever #5 pclk = ~pclk;
    end

    // program store, one cycle late; word tags page and pointer, idle bus keeps toggling
    always @(posedge pclk) begin
        rom_data <= rom_rd ? {3'h5, rom_addr} : ~rom_data;
    end

    // hang guard, well above the length of the run
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end

    task automatic conclude();
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer; request held until ready is seen at an edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic ckr(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        ck(rdat, e, "read");
    endtask

    task automatic errw(input logic [11:0] a);
        xfer(1'b1, a, 32'hff);
        ck({31'h0, rerr}, 32'h1, "refused");
    endtask

    // load operands, run one op on memory word 3, then judge status, acc, memory, flags
    task automatic rc(input logic [4:0] op, input logic [2:0] bs, input logic [7:0] m,
        input logic [7:0] a, input logic [3:0] f, input logic [7:0] ea, input logic [7:0] em,
        input logic [3:0] ef, input logic [1:0] cy);
        int n;
        cmd_t c;
        c = '0;
        c.op = op;
        c.bit_sel = bs;
        c.idx = 3'h3;
        wr(ADDR_MEM + 12'h00c, {24'h0, m});
        wr(ADDR_ACC, {24'h0, a});
        wr(ADDR_FLAGS, {28'h0, f});
        wr(ADDR_IMM, {24'h0, m});
        wr(ADDR_CMD, c);
        n = 0;
        do begin
            xfer(1'b0, ADDR_STAT, 32'h0);
            n++;
        end while (rdat[0] !== 1'b0 && n < 8);
        ck(rdat & 32'h33, {26'h0, cy, 2'h0, cy == 2'h2, 1'b0}, "status");
        ckr(ADDR_ACC, {24'h0, ea});
        ckr(ADDR_MEM + 12'h00c, {24'h0, em});
        ckr(ADDR_FLAGS, {28'h0, ef});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    // reset values and refused accesses
    task automatic t_bus();
        ckr(ADDR_ACC, 32'h0);
        ckr(ADDR_STAT, 32'h0);
        xfer(1'b0, 12'h100, 32'h0);
        ck(rdat, 32'h0, "unmapped data");
        ck({31'h0, rerr}, 32'h1, "unmapped");
        errw(12'h006);
        errw(ADDR_MEM + 12'h020);
        errw(ADDR_HIGH);
        ckr(ADDR_HIGH, 32'h0);
    endtask

    task automatic t_rot();
        rc(5'h00,3'h0,8'h16,8'h11,4'hb,8'h11,8'h2d,4'ha,2'h1);
        rc(5'h01,3'h0,8'h96,8'h11,4'h4,8'h2c,8'h96,4'h5,2'h1);
        rc(5'h02,3'h0,8'h96,8'h11,4'h9,8'h11,8'h4b,4'h9,2'h1);
        rc(5'h03,3'h0,8'h97,8'h11,4'h6,8'hcb,8'h97,4'h6,2'h1);
        rc(5'h04,3'h0,8'h97,8'h11,4'h0,8'h11,8'h4b,4'h1,2'h1);
        rc(5'h05,3'h0,8'h96,8'h11,4'h3,8'hcb,8'h96,4'h2,2'h1);
    endtask

    task automatic t_sub();
        rc(5'h06,3'h0,8'h30,8'h50,4'h0,8'h1f,8'h30,4'h1,2'h1);
        rc(5'h07,3'h0,8'h01,8'h80,4'h1,8'h80,8'h7f,4'h9,2'h1);
        rc(5'h08,3'h0,8'h34,8'h34,4'h0,8'h00,8'h34,4'h7,2'h1);
        rc(5'h09,3'h0,8'h20,8'h10,4'hf,8'h10,8'hf0,4'h2,2'h1);
        rc(5'h0a,3'h0,8'h06,8'h05,4'hf,8'hff,8'h06,4'h0,2'h1);
    endtask

    // taken and untaken skips, each run to idle before the next
    task automatic t_skip();
        rc(5'h0b,3'h0,8'h01,8'h11,4'h5,8'h11,8'h00,4'h5,2'h2);
        rc(5'h0b,3'h0,8'h00,8'h11,4'h5,8'h11,8'hff,4'h5,2'h1);
        rc(5'h0c,3'h0,8'h01,8'h11,4'ha,8'h00,8'h01,4'ha,2'h2);
        rc(5'h0c,3'h0,8'h02,8'h11,4'ha,8'h01,8'h02,4'ha,2'h1);
        rc(5'h0d,3'h0,8'h00,8'h11,4'h3,8'h11,8'h00,4'h3,2'h2);
        rc(5'h0d,3'h0,8'h80,8'h11,4'h3,8'h11,8'h80,4'h3,2'h1);
        rc(5'h0e,3'h0,8'h00,8'h11,4'hc,8'h00,8'h00,4'hc,2'h2);
        rc(5'h0e,3'h0,8'h5a,8'h11,4'hc,8'h5a,8'h5a,4'hc,2'h1);
        rc(5'h0f,3'h3,8'hf7,8'h11,4'h6,8'h11,8'hf7,4'h6,2'h2);
        rc(5'h0f,3'h7,8'hf7,8'h11,4'h6,8'h11,8'hf7,4'h6,2'h1);
        rc(5'h0f,3'h0,8'hfe,8'h11,4'h6,8'h11,8'hfe,4'h6,2'h2);
    endtask

    task automatic t_nib_xor();
        rc(5'h10,3'h0,8'h3c,8'h11,4'h9,8'h11,8'hc3,4'h9,2'h1);
        rc(5'h11,3'h0,8'h3c,8'h11,4'h6,8'hc3,8'h3c,4'h6,2'h1);
        rc(5'h14,3'h0,8'h5a,8'h5a,4'hb,8'h00,8'h5a,4'hf,2'h1);
        rc(5'h15,3'h0,8'hf0,8'h0f,4'h4,8'h0f,8'hff,4'h0,2'h1);
        rc(5'h16,3'h0,8'h0f,8'h0f,4'h0,8'h00,8'h0f,4'h4,2'h1);
    endtask

    // page 4 versus the fixed last page, pointer lands in memory; busy refuses a command
    task automatic t_tbl();
        wr(ADDR_PTR, 32'h3c);
        wr(ADDR_PAGE, 32'h04);
        rc(5'h12,3'h0,8'h00,8'h11,4'h5,8'h11,8'h3c,4'h5,2'h1);
        ckr(ADDR_HIGH, 32'ha4);
        wr(ADDR_PTR, 32'hc5);
        rc(5'h13,3'h0,8'h00,8'h11,4'ha,8'h11,8'hc5,4'ha,2'h1);
        ckr(ADDR_HIGH, 32'hbf);
        wr(ADDR_CMD, 32'h12);
        errw(ADDR_CMD);
        ckr(ADDR_HIGH, 32'ha4);
    endtask

    // reset for 20 cycles, then the scenarios in turn
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_bus();
        t_rot();
        t_sub();
        t_skip();
        t_nib_xor();
        t_tbl();
        conclude();
    end
endmodule
